// ===== rtl/xfm_top.sv
`default_nettype none
// Notes on behaviour
// - window enable set maps fifo ram at 0x0400 to 0x07FF
// - while enabled, normal ram in that range is unreachable
// - fifo moves take more cycles than on-chip ram moves
// - unused fifo ram usable as general storage via window
// - bit 6 of config blocks (0) or allows (1) fifo access
// - 8-bit moves take high byte from page register, reset zero
// - four memory modes selected in config register
// - multiplexed or separate bus chosen by config bit
// - off-chip bus appears on ports 4, 3, 2 and 1
// - pins claimed only during an off-chip move
// - drivers off on input pins, data lines during read
// - push-pull or open-drain mode left untouched
// - bank-select split: below 8k on-chip, above off-chip
// - mode 11: off-chip only, on-chip ram invisible
module xfm_top
  import xfm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  input  wire logic        mv_req,
  input  wire logic        mv_write,
  input  wire logic        mv_short,
  input  wire logic [15:0] mv_addr,
  input  wire logic [7:0]  mv_wdata,
  output var  logic        mv_done,
  output var  logic [7:0]  mv_rdata,
  output var  logic        onchip_sel,
  output var  logic        fifo_sel,
  output var  logic [15:0] mem_addr,
  output var  logic [7:0]  mem_wdata,
  output var  logic        mem_we,
  input  wire logic [7:0]  onchip_rdata,
  input  wire logic [7:0]  fifo_rdata,
  output var  logic        pins_claimed,
  output var  logic        bus_multiplexed,
  output var  logic [1:0]  latch_pulse_width,
  output var  logic [15:0] ext_addr_out,
  output var  logic [7:0]  ext_data_out,
  output var  logic        ext_data_oe,
  input  wire logic [7:0]  ext_data_in,
  output var  logic        ext_rd_n,
  output var  logic        ext_wr_n
);
  import xfm_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} xfm_state_t;
  typedef struct packed {
    xfm_state_t  state;
    logic [7:0]  cfg;
    logic [7:0]  page;
    logic [3:0]  cnt;
    xfm_target_t tgt;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  sfr_rdata;
    logic        done;
    logic        claimed;
    logic        data_oe;
    logic        rd_n;
    logic        wr_n;
    logic        onchip_sel;
    logic        fifo_sel;
    logic        multiplexed;
    logic [7:0]  ext_s1;
    logic [7:0]  ext_s2;
    logic [7:0]  ext_s3;
    logic [7:0]  ext_filt;
  } xfm_regs_t;

  xfm_regs_t st_reg;
  xfm_regs_t st_next;

  function automatic xfm_target_t decode(input logic [7:0] cfg, input logic [15:0] a);
    xfm_mode_t m;
    m = xfm_mode_t'(cfg[MODE_LSB +: 2]);
    if (cfg[FIFO_EN_BIT] && a >= FIFO_WIN_LO && a <= FIFO_WIN_HI) begin
      decode = TGT_FIFO;
    end else begin
      unique case (m)
        MODE_ONCHIP:     decode = TGT_ONCHIP;
        MODE_SPLIT:      decode = (a < ONCHIP_SIZE) ? TGT_ONCHIP : TGT_OFFCHIP;
        MODE_SPLIT_BANK: decode = (a < BANK_BOUNDARY) ? TGT_ONCHIP : TGT_OFFCHIP;
        MODE_OFFCHIP:    decode = TGT_OFFCHIP;
      endcase
    end
  endfunction

  logic [15:0] eff_addr;
  xfm_target_t eff_tgt;
  logic [7:0]  ext_settled;

  always_comb begin
    eff_addr = mv_short ? {st_reg.page, mv_addr[7:0]} : mv_addr;
    eff_tgt  = decode(st_reg.cfg, eff_addr);
    // a settled byte is taken straight from stage three, so a read needs no extra wait
    ext_settled = (st_reg.ext_s2 == st_reg.ext_s3) ? st_reg.ext_s3 : st_reg.ext_filt;
    st_next = st_reg;
    st_next.done = 1'b0;
    // ****************************************************************
    // data pin synchroniser
    // ****************************************************************
    // the bus is asynchronous to the core, so a change counts only once two stages agree
    st_next.ext_s1 = ext_data_in;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_s3 = st_reg.ext_s2;
    if (st_reg.ext_s2 == st_reg.ext_s3) begin
      st_next.ext_filt = st_reg.ext_s3;
    end
    // ****************************************************************
    // register port
    // ****************************************************************
    if (sfr_wr && sfr_addr == MEM_IF_CFG_ADDR) begin
      st_next.cfg = sfr_wdata & MEM_IF_CFG_WMASK;
    end
    if (sfr_wr && sfr_addr == PAGE_SEL_ADDR) begin
      st_next.page = sfr_wdata;
    end
    unique case (sfr_addr)
      MEM_IF_CFG_ADDR: st_next.sfr_rdata = st_reg.cfg;
      PAGE_SEL_ADDR:   st_next.sfr_rdata = st_reg.page;
      default:         st_next.sfr_rdata = 8'h00;
    endcase
    // ****************************************************************
    // move sequencer
    // ****************************************************************
    unique case (st_reg.state)
      ST_IDLE: begin
        if (mv_req) begin
          st_next.state = ST_BUSY;
          st_next.tgt   = eff_tgt;
          st_next.we    = mv_write;
          st_next.addr  = eff_addr;
          st_next.wdata = mv_wdata;
          unique case (eff_tgt)
            TGT_ONCHIP:  st_next.cnt = ONCHIP_CYCLES;
            TGT_FIFO:    st_next.cnt = FIFO_CYCLES;
            TGT_OFFCHIP: st_next.cnt = OFFCHIP_CYCLES;
            default:     st_next.cnt = ONCHIP_CYCLES;
          endcase
          if (eff_tgt == TGT_OFFCHIP) begin
            st_next.claimed = 1'b1;
            st_next.data_oe = mv_write;
            st_next.rd_n    = mv_write;
            st_next.wr_n    = ~mv_write;
          end
        end
      end
      ST_BUSY: begin
        st_next.cnt = st_reg.cnt - CNT_ONE;
        if (st_reg.cnt == CNT_ONE) begin
          st_next.state = ST_DONE;
          st_next.done  = 1'b1;
          unique case (st_reg.tgt)
            TGT_FIFO:    st_next.rdata = fifo_rdata;
            TGT_OFFCHIP: st_next.rdata = ext_settled;
            default:     st_next.rdata = onchip_rdata;
          endcase
          st_next.claimed = 1'b0;
          st_next.data_oe = 1'b0;
          st_next.rd_n    = 1'b1;
          st_next.wr_n    = 1'b1;
        end
      end
      ST_DONE: begin
        st_next.state = ST_IDLE;
      end
      default: st_next.state = ST_IDLE;
    endcase
    // ****************************************************************
    // registered selects and bus mode
    // ****************************************************************
    // selects follow the next state so they leave a flip-flop in step with it
    st_next.onchip_sel  = (st_next.state == ST_BUSY) && (st_next.tgt == TGT_ONCHIP);
    st_next.fifo_sel    = (st_next.state == ST_BUSY) && (st_next.tgt == TGT_FIFO);
    st_next.multiplexed = ~st_next.cfg[MUX_SEL_BIT];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{state: ST_IDLE, cfg: MEM_IF_CFG_RESET, page: PAGE_SEL_RESET, cnt: CNT_ZERO,
                  tgt: TGT_ONCHIP, we: 1'b0, addr: 16'h0000, wdata: 8'h00, rdata: 8'h00,
                  sfr_rdata: 8'h00, done: 1'b0, claimed: 1'b0, data_oe: 1'b0,
                  rd_n: 1'b1, wr_n: 1'b1, onchip_sel: 1'b0, fifo_sel: 1'b0,
                  multiplexed: ~MEM_IF_CFG_RESET[MUX_SEL_BIT], ext_s1: 8'h00, ext_s2: 8'h00,
                  ext_s3: 8'h00, ext_filt: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic busy_q;
  always_comb busy_q = (st_reg.state == ST_BUSY);
  assign sfr_rdata         = st_reg.sfr_rdata;
  assign mv_done           = st_reg.done;
  assign mv_rdata          = st_reg.rdata;
  assign onchip_sel        = st_reg.onchip_sel;
  assign fifo_sel          = st_reg.fifo_sel;
  assign mem_addr          = st_reg.addr;
  assign mem_wdata         = st_reg.wdata;
  assign mem_we            = st_reg.we;
  assign pins_claimed      = st_reg.claimed;
  assign bus_multiplexed   = st_reg.multiplexed;
  assign latch_pulse_width = st_reg.cfg[1:0];
  assign ext_addr_out      = st_reg.addr;
  assign ext_data_out      = st_reg.wdata;
  assign ext_data_oe       = st_reg.data_oe;
  assign ext_rd_n          = st_reg.rd_n;
  assign ext_wr_n          = st_reg.wr_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_window_to_fifo: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && st_reg.cfg[FIFO_EN_BIT] && eff_addr >= FIFO_WIN_LO
     && eff_addr <= FIFO_WIN_HI) |=> fifo_sel && !pins_claimed)
    else $error("window access not routed to fifo");
  a_window_blocked: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && !st_reg.cfg[FIFO_EN_BIT]) |=> !fifo_sel)
    else $error("fifo reached while window disabled");
  a_fifo_slower: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(fifo_sel) |-> fifo_sel [*3] ##1 !fifo_sel)
    else $error("fifo access length wrong");
  a_onchip_one: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(onchip_sel) |=> !onchip_sel)
    else $error("on-chip access length wrong");
  a_page_high: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && mv_short) |=> mem_addr[15:8] == $past(st_reg.page))
    else $error("page byte not used");
  a_claim_only_move: assert property (@(posedge clock) disable iff (sys_rst)
    pins_claimed |-> busy_q && st_reg.tgt == TGT_OFFCHIP)
    else $error("pins claimed outside off-chip move");
  a_read_no_drive: assert property (@(posedge clock) disable iff (sys_rst)
    (pins_claimed && !mem_we) |-> !ext_data_oe && !ext_rd_n)
    else $error("data driven during read");
  a_mode_offchip: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.cfg[MODE_LSB +: 2] == MODE_OFFCHIP) |-> !onchip_sel)
    else $error("on-chip visible in external only mode");
  a_bank_split: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && st_reg.cfg[MODE_LSB +: 2] == MODE_SPLIT_BANK && eff_addr >= BANK_BOUNDARY)
    |=> pins_claimed)
    else $error("bank split high address not off-chip");
  a_done_after: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(pins_claimed) |-> mv_done)
    else $error("claim released without done");
  c_fifo_move: cover property (@(posedge clock) disable iff (sys_rst) $rose(fifo_sel));
  c_off_read: cover property (@(posedge clock) disable iff (sys_rst) pins_claimed && !mem_we);
  c_off_write: cover property (@(posedge clock) disable iff (sys_rst) pins_claimed && mem_we);
  c_short_move: cover property (@(posedge clock) disable iff (sys_rst) mv_req && mv_short);
  c_bank_high: cover property (@(posedge clock) disable iff (sys_rst)
    pins_claimed && st_reg.cfg[MODE_LSB +: 2] == MODE_SPLIT_BANK);
  // config, routing, pin control, counter and done pulse
  a_cfg_unused: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.cfg & ~MEM_IF_CFG_WMASK) == 8'h00)
    else $error("unused config bits set");
  a_sel_exclusive: assert property (@(posedge clock) disable iff (sys_rst)
    !(onchip_sel && fifo_sel))
    else $error("on-chip and fifo selected together");
  a_fifo_no_pins: assert property (@(posedge clock) disable iff (sys_rst)
    fifo_sel |-> !pins_claimed)
    else $error("pins claimed during fifo access");
  a_onchip_mode: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && st_reg.cfg[MODE_LSB +: 2] == MODE_ONCHIP && !st_reg.cfg[FIFO_EN_BIT])
    |=> onchip_sel && !pins_claimed)
    else $error("on-chip only mode left the chip");
  a_split_low: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && st_reg.cfg[MODE_LSB +: 2] == MODE_SPLIT && !st_reg.cfg[FIFO_EN_BIT]
     && eff_addr < ONCHIP_SIZE) |=> onchip_sel)
    else $error("split low address not on-chip");
  a_claim_offchip: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.state == ST_IDLE && mv_req && eff_tgt == TGT_OFFCHIP)
    |=> pins_claimed && ext_addr_out == $past(eff_addr))
    else $error("off-chip move did not drive the bus");
  a_write_drives: assert property (@(posedge clock) disable iff (sys_rst)
    (pins_claimed && mem_we) |-> ext_data_oe && !ext_wr_n && ext_rd_n)
    else $error("off-chip write not driven");
  a_strobes_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !pins_claimed |-> ext_rd_n && ext_wr_n && !ext_data_oe)
    else $error("bus driven while pins released");
  a_cnt_bounds: assert property (@(posedge clock) disable iff (sys_rst)
    st_reg.cnt <= OFFCHIP_CYCLES)
    else $error("move counter out of range");
  a_done_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    mv_done |=> !mv_done)
    else $error("done longer than one cycle");
endmodule
`default_nettype wire

// ===== rtl/xfm_pkg.sv
`default_nettype none
package xfm_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] MEM_IF_CFG_ADDR   = 8'h85;
  localparam logic [7:0] PAGE_SEL_ADDR     = 8'hAA;
  localparam logic [7:0] MEM_IF_CFG_RESET  = 8'h03;
  localparam logic [7:0] PAGE_SEL_RESET    = 8'h00;
  localparam logic [7:0] MEM_IF_CFG_WMASK  = 8'h5F;
  localparam int         FIFO_EN_BIT       = 6;
  localparam int         MUX_SEL_BIT       = 4;
  localparam int         MODE_LSB          = 2;
  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [15:0] FIFO_WIN_LO      = 16'h0400;
  localparam logic [15:0] FIFO_WIN_HI      = 16'h07FF;
  localparam logic [15:0] BANK_BOUNDARY    = 16'h2000;
  localparam logic [15:0] ONCHIP_SIZE      = 16'h1000;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [3:0] ONCHIP_CYCLES     = 4'h1;
  localparam logic [3:0] FIFO_CYCLES       = 4'h3;
  localparam logic [3:0] OFFCHIP_CYCLES    = 4'h4;
  localparam logic [3:0] CNT_ONE           = 4'h1;
  localparam logic [3:0] CNT_ZERO          = 4'h0;
  typedef enum logic [1:0] {
    MODE_ONCHIP,
    MODE_SPLIT,
    MODE_SPLIT_BANK,
    MODE_OFFCHIP
  } xfm_mode_t;
  typedef enum logic [1:0] {
    TGT_ONCHIP,
    TGT_FIFO,
    TGT_OFFCHIP
  } xfm_target_t;
endpackage
`default_nettype wire

// ===== test/xfm_ext_mem.sv
`default_nettype none
// ****************************************************************
// off-chip data memory on the external bus
// ****************************************************************
module xfm_ext_mem (
  input  wire logic        clock,
  input  wire logic [15:0] ext_addr_out,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  output var  logic [7:0]  ext_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last_q;
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end
  // strobes arrive on their own skipped lines all lines taken as push-pull driven
  always @(posedge clock) begin
    if (!ext_wr_n) mem[ext_addr_out[7:0]] <= ext_data_out;
    last_q <= ext_data_in;
  end
  // released data lines show the inverse of the last value, so stale data never matches
  assign ext_data_in = !ext_rd_n ? mem[ext_addr_out[7:0]] : ~last_q;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`default_nettype none
module tb_top;
  import xfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, sfr_wr, mv_req, mv_write, mv_short, mv_done, onchip_sel, fifo_sel, mem_we;
  logic pins_claimed, bus_multiplexed, ext_data_oe, ext_rd_n, ext_wr_n;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, mv_wdata, mv_rdata, mem_wdata, ext_data_out, ext_data_in, pg;
  logic [7:0]  onchip_rdata, fifo_rdata;
  logic [15:0] mv_addr, mem_addr, ext_addr_out;
  logic [1:0]  latch_pulse_width;
  int miscompares, checks_done;
  xfm_top dut_u (.clock(clock), .sys_rst(sys_rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mv_req(mv_req), .mv_write(mv_write),
    .mv_short(mv_short), .mv_addr(mv_addr), .mv_wdata(mv_wdata), .mv_done(mv_done), .mv_rdata(mv_rdata),
    .onchip_sel(onchip_sel), .fifo_sel(fifo_sel), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .onchip_rdata(onchip_rdata), .fifo_rdata(fifo_rdata), .pins_claimed(pins_claimed),
    .bus_multiplexed(bus_multiplexed), .latch_pulse_width(latch_pulse_width),
    .ext_addr_out(ext_addr_out), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_data_in(ext_data_in), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
  xfm_ext_mem mem_u (.clock(clock), .ext_addr_out(ext_addr_out), .ext_data_out(ext_data_out),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_data_in(ext_data_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // on-chip and fifo ram behind the select ports; the fifo side acts as if its usb clock were live
  logic [7:0] fifo_ram [1024];
  logic [7:0] chip_ram [256];
  initial begin
    for (int i = 0; i < 1024; i++) fifo_ram[i] = 8'h5A;
    for (int i = 0; i < 256; i++) chip_ram[i] = 8'h96;
  end
  always @(posedge clock) begin
    if (fifo_sel && mem_we) fifo_ram[mem_addr[9:0]] <= mem_wdata;
    if (onchip_sel && mem_we) chip_ram[mem_addr[7:0]] <= mem_wdata;
  end
  assign fifo_rdata   = fifo_ram[mem_addr[9:0]];
  assign onchip_rdata = chip_ram[mem_addr[7:0]];
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    if (a == PAGE_SEL_ADDR) pg = d;
    @(posedge clock);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 sfr_addr = a;
    @(posedge clock);
    #1 chk(16'(sfr_rdata), 16'(e), "register read");
  endtask
  // one move; n is the busy length, t the expected target
  task automatic mv(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d,
                    input xfm_target_t t, input int n, input logic [7:0] e);
    int k;
    logic pc, fs, os, oe;
    logic [15:0] ea;
    pc = 1'b0;
    fs = 1'b0;
    os = 1'b0;
    oe = 1'b0;
    ea = 16'h0000;
    @(posedge clock);
    #1 mv_req = 1'b1;
    mv_write = w;
    mv_short = s;
    mv_addr = a;
    mv_wdata = d;
    @(posedge clock);
    #1 mv_req = 1'b0;
    k = 1;
    while (mv_done !== 1'b1 && k < 20) begin
      pc |= pins_claimed;
      fs |= fifo_sel;
      os |= onchip_sel;
      oe |= ext_data_oe;
      if (pins_claimed === 1'b1) ea = ext_addr_out;
      @(posedge clock);
      #1 k++;
    end
    chk(16'(k), 16'(n + 1), "move length");
    chk({13'h0, pc, fs, os}, {13'h0, t == TGT_OFFCHIP, t == TGT_FIFO, t == TGT_ONCHIP}, "target");
    chk(16'(oe), 16'(w && t == TGT_OFFCHIP), "data drive enable");
    if (t == TGT_OFFCHIP) chk(ea, s ? {pg, a[7:0]} : a, "pin address");
    if (!w) chk(16'(mv_rdata), 16'(e), "move read data");
    chk({14'h0, pins_claimed, ext_rd_n & ext_wr_n}, 16'h0001, "pins released");
    if (k >= 20) wrap_up();
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {sfr_wr, mv_req, mv_write, mv_short} = 4'h0;
    {sfr_addr, sfr_wdata, mv_wdata, pg} = 32'h0;
    mv_addr = 16'h0000;
    miscompares = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clock);
    #1 sys_rst = 1'b0;
    chk({15'h0, bus_multiplexed}, 16'h0001, "reset bus mode");
    rd(MEM_IF_CFG_ADDR, 8'h03);
    rd(PAGE_SEL_ADDR, 8'h00);
    rd(8'h11, 8'h00);
    wr(MEM_IF_CFG_ADDR, 8'hFF);
    rd(MEM_IF_CFG_ADDR, 8'h5F);
    chk({14'h0, bus_multiplexed, 1'b0}, 16'h0, "separate bus");
    chk(16'(latch_pulse_width), 16'h0003, "latch width");
    wr(MEM_IF_CFG_ADDR, 8'h02);
    chk({14'h0, bus_multiplexed, latch_pulse_width[1]}, 16'h0003, "multiplexed bus");
    wr(MEM_IF_CFG_ADDR, 8'h10);
    mv(1'b0, 1'b0, 16'h0500, 8'h00, TGT_ONCHIP, 1, 8'h96);
    mv(1'b0, 1'b0, 16'h3000, 8'h00, TGT_ONCHIP, 1, 8'h96);
    mv(1'b1, 1'b0, 16'h0123, 8'h77, TGT_ONCHIP, 1, 8'h00);
    mv(1'b0, 1'b0, 16'h0123, 8'h00, TGT_ONCHIP, 1, 8'h77);
    wr(MEM_IF_CFG_ADDR, 8'h1C);
    mv(1'b1, 1'b0, 16'h0555, 8'hA5, TGT_OFFCHIP, 4, 8'h00);
    mv(1'b0, 1'b0, 16'h0555, 8'h00, TGT_OFFCHIP, 4, 8'hA5);
    wr(MEM_IF_CFG_ADDR, 8'h5C);
    mv(1'b0, 1'b0, 16'h0400, 8'h00, TGT_FIFO, 3, 8'h5A);
    mv(1'b0, 1'b0, 16'h07FF, 8'h00, TGT_FIFO, 3, 8'h5A);
    mv(1'b1, 1'b0, 16'h0555, 8'h11, TGT_FIFO, 3, 8'h00);
    mv(1'b0, 1'b0, 16'h0555, 8'h00, TGT_FIFO, 3, 8'h11);
    mv(1'b0, 1'b0, 16'h03FF, 8'h00, TGT_OFFCHIP, 4, 8'hC3);
    mv(1'b0, 1'b0, 16'h0800, 8'h00, TGT_OFFCHIP, 4, 8'h3C);
    wr(MEM_IF_CFG_ADDR, 8'h58);
    mv(1'b0, 1'b0, 16'h0600, 8'h00, TGT_FIFO, 3, 8'h5A);
    mv(1'b0, 1'b0, 16'h1FFF, 8'h00, TGT_ONCHIP, 1, 8'h96);
    mv(1'b0, 1'b0, 16'h2000, 8'h00, TGT_OFFCHIP, 4, 8'h3C);
    wr(MEM_IF_CFG_ADDR, 8'h14);
    mv(1'b0, 1'b0, 16'h0FFF, 8'h00, TGT_ONCHIP, 1, 8'h96);
    mv(1'b0, 1'b0, 16'h1000, 8'h00, TGT_OFFCHIP, 4, 8'h3C);
    mv(1'b0, 1'b0, 16'h0555, 8'h00, TGT_ONCHIP, 1, 8'h96);
    wr(PAGE_SEL_ADDR, 8'h12);
    rd(PAGE_SEL_ADDR, 8'h12);
    wr(MEM_IF_CFG_ADDR, 8'h1C);
    mv(1'b0, 1'b1, 16'hFF34, 8'h00, TGT_OFFCHIP, 4, 8'h08);
    wrap_up();
  end
endmodule
`default_nettype wire
